// *** aab_pkg.sv ***
// Package with register map, field codes, reset values and carrier types.
package aab_pkg;

    // Register addresses (zero-based holding register addresses).
    localparam logic [15:0] ADDR_SETPOINT        = 16'h0000;
    localparam logic [15:0] ADDR_OVERRIDE        = 16'h0001;
    localparam logic [15:0] ADDR_MALFUNCTION     = 16'h0068;
    localparam logic [15:0] ADDR_VMAX            = 16'h006a;
    localparam logic [15:0] ADDR_SENSOR_TYPE     = 16'h006b;
    localparam logic [15:0] ADDR_LOSS_POSITION   = 16'h006c;
    localparam logic [15:0] ADDR_LOSS_TIMEOUT    = 16'h006d;
    localparam logic [15:0] ADDR_RATED_M3H       = 16'h006e;
    localparam logic [15:0] ADDR_RATED_UNIT_LOW  = 16'h0070;
    localparam logic [15:0] ADDR_RATED_UNIT_HIGH = 16'h0071;
    localparam logic [15:0] ADDR_REGULATION_MODE = 16'h0074;
    localparam logic [15:0] ADDR_FLOW_UNIT       = 16'h0075;
    localparam logic [15:0] ADDR_SETPOINT_ORIGIN = 16'h0076;
    localparam logic [15:0] ADDR_ANALOG_MV       = 16'h0077;

    // Field codes.
    localparam logic [2:0]  SENSOR_NONE        = 3'h0;
    localparam logic [2:0]  SENSOR_ACTIVE      = 3'h1;
    localparam logic [2:0]  SENSOR_SWITCH      = 3'h4;
    localparam logic [1:0]  LOSS_POS_LAST      = 2'h0;
    localparam logic [2:0]  FLOW_UNIT_MAX      = 3'h6;
    localparam logic        ORIGIN_ANALOG      = 1'h0;
    localparam logic        ORIGIN_BUS         = 1'h1;
    localparam int unsigned MALF_WATCHDOG_BIT  = 10;

    // Values after reset.
    localparam logic [15:0] RST_VMAX           = 16'h2710;
    localparam logic [2:0]  RST_SENSOR_TYPE    = 3'h0;
    localparam logic [1:0]  RST_LOSS_POSITION  = 2'h0;
    localparam logic [11:0] RST_LOSS_TIMEOUT   = 12'h000;
    localparam logic [11:0] DFLT_ARMED_TIMEOUT = 12'h078;
    localparam logic [11:0] MAX_LOSS_TIMEOUT   = 12'he10;
    localparam logic        RST_REG_MODE       = 1'h0;
    localparam logic [2:0]  RST_FLOW_UNIT      = 3'h1;
    localparam logic        RST_ORIGIN         = 1'h1;

    // Watchdog time base: one second at the core clock rate.
    localparam int unsigned WD_TICK_S       = 1;
    localparam int unsigned CORE_CLK_MHZ    = 250;
    localparam int unsigned WD_TICK_CYCLES  = WD_TICK_S * CORE_CLK_MHZ * 1000000;

    typedef struct packed {
        logic        en;
        logic [15:0] addr;
        logic [15:0] data;
    } aab_wr_type;

    typedef struct packed {
        logic        en;
        logic [15:0] addr;
    } aab_rd_type;

    typedef struct packed {
        logic [15:0] vmax;
        logic [2:0]  sensor_type;
        logic [1:0]  loss_position;
        logic [11:0] loss_timeout_s;
        logic        timeout_set;
        logic        regulation_mode;
        logic [2:0]  selected_flow_unit;
        logic        setpoint_origin;
    } aab_cfg_type;

endpackage

// *** aab_regs.sv ***
// Watchdog and configuration holding registers of the airflow actuator.
`timescale 1ns/1ns
`default_nettype none
// How it works
// - Sensor type codes 0,1,4; resets to 0.
// - Analog setpoint mV readable in hybrid mode.
// - No setpoint/override refresh in time: bus failure.
// - Fail position codes 0..3; resets to 0.
// - Monitoring off keeps last setpoint.
// - Triggered watchdog flagged in malfunction register.
// - Watchdog flag is malfunction bit 10.
// - Timeout 0..3600 s; zero disables watchdog.
// - Timeout defaults 120 s if position nonzero.
// - Fail position driven only after expiry, nonzero.
// - Rated flow 32-bit, low word then high.
// - Flow unit codes 0..6; resets to 1.
// - Setpoint origin analog or bus; resets bus.
module aab_regs #(
    parameter int unsigned TICK_CYCLES = aab_pkg::WD_TICK_CYCLES
) (
    input  wire logic               i_core_clk,
    input  wire logic               i_resetn,
    input  wire aab_pkg::aab_wr_type i_wr,
    input  wire aab_pkg::aab_rd_type i_rd,
    input  wire logic [15:0]        i_malfunction_bits,
    input  wire logic [15:0]        i_rated_flow_m3h,
    input  wire logic [31:0]        i_rated_flow_unit,
    input  wire logic [15:0]        i_analog_mv,
    output logic [15:0]             o_rd_data,
    output logic                    o_rd_valid,
    output aab_pkg::aab_cfg_type    o_cfg,
    output logic                    o_watchdog_tripped,
    output logic                    o_fail_active
);

    aab_pkg::aab_cfg_type cfg_ff;
    aab_pkg::aab_cfg_type nxt_cfg;
    logic [31:0]          tick_cnt_ff;
    logic [31:0]          nxt_tick_cnt;
    logic [11:0]          sec_cnt_ff;
    logic [11:0]          nxt_sec_cnt;
    logic                 tripped_ff;
    logic                 nxt_tripped;
    logic                 fail_active_ff;
    logic                 nxt_fail_active;
    logic [15:0]          rd_data_ff;
    logic [15:0]          nxt_rd_data;
    logic                 rd_valid_ff;
    logic                 nxt_rd_valid;
    logic [11:0]          eff_timeout;
    logic                 refresh;
    logic                 tick;
    logic [15:0]          malf_word;

    always_comb begin
        if (cfg_ff.timeout_set) begin
            eff_timeout = cfg_ff.loss_timeout_s;
        end else if (cfg_ff.loss_position != aab_pkg::LOSS_POS_LAST) begin
            eff_timeout = aab_pkg::DFLT_ARMED_TIMEOUT;
        end else begin
            eff_timeout = aab_pkg::RST_LOSS_TIMEOUT;
        end
    end

    assign refresh = i_wr.en
                     && (i_wr.addr == aab_pkg::ADDR_SETPOINT
                         || i_wr.addr == aab_pkg::ADDR_OVERRIDE);
    assign tick = (tick_cnt_ff == TICK_CYCLES - 1);

    // Illegal codes are dropped so the fields always hold a defined mode.
    always_comb begin
        nxt_cfg = cfg_ff;
        if (i_wr.en) begin
            case (i_wr.addr)
                aab_pkg::ADDR_VMAX: begin
                    nxt_cfg.vmax = i_wr.data;
                end
                aab_pkg::ADDR_SENSOR_TYPE: begin
                    if (i_wr.data[15:3] == 13'h0000
                        && (i_wr.data[2:0] == aab_pkg::SENSOR_NONE
                            || i_wr.data[2:0] == aab_pkg::SENSOR_ACTIVE
                            || i_wr.data[2:0] == aab_pkg::SENSOR_SWITCH)) begin
                        nxt_cfg.sensor_type = i_wr.data[2:0];
                    end
                end
                aab_pkg::ADDR_LOSS_POSITION: begin
                    if (i_wr.data[15:2] == 14'h0000) begin
                        nxt_cfg.loss_position = i_wr.data[1:0];
                    end
                end
                aab_pkg::ADDR_LOSS_TIMEOUT: begin
                    if (i_wr.data[15:12] == 4'h0
                        && i_wr.data[11:0] <= aab_pkg::MAX_LOSS_TIMEOUT) begin
                        nxt_cfg.loss_timeout_s = i_wr.data[11:0];
                        nxt_cfg.timeout_set    = 1'b1;
                    end
                end
                aab_pkg::ADDR_REGULATION_MODE: begin
                    if (i_wr.data[15:1] == 15'h0000) begin
                        nxt_cfg.regulation_mode = i_wr.data[0];
                    end
                end
                aab_pkg::ADDR_FLOW_UNIT: begin
                    if (i_wr.data[15:3] == 13'h0000
                        && i_wr.data[2:0] <= aab_pkg::FLOW_UNIT_MAX) begin
                        nxt_cfg.selected_flow_unit = i_wr.data[2:0];
                    end
                end
                aab_pkg::ADDR_SETPOINT_ORIGIN: begin
                    if (i_wr.data[15:1] == 15'h0000) begin
                        nxt_cfg.setpoint_origin = i_wr.data[0];
                    end
                end
                default: begin
                    nxt_cfg = cfg_ff;
                end
            endcase
        end
    end

    always_ff @(posedge i_core_clk or negedge i_resetn) begin
        if (!i_resetn) begin
            cfg_ff.vmax               <= aab_pkg::RST_VMAX;
            cfg_ff.sensor_type        <= aab_pkg::RST_SENSOR_TYPE;
            cfg_ff.loss_position      <= aab_pkg::RST_LOSS_POSITION;
            cfg_ff.loss_timeout_s     <= aab_pkg::RST_LOSS_TIMEOUT;
            cfg_ff.timeout_set        <= 1'b0;
            cfg_ff.regulation_mode    <= aab_pkg::RST_REG_MODE;
            cfg_ff.selected_flow_unit <= aab_pkg::RST_FLOW_UNIT;
            cfg_ff.setpoint_origin    <= aab_pkg::RST_ORIGIN;
        end else begin
            cfg_ff <= nxt_cfg;
        end
    end

    // Watchdog: second divider, second counter and trip flag.
    always_comb begin
        nxt_tick_cnt = tick ? 32'h0000_0000 : tick_cnt_ff + 32'h0000_0001;
        nxt_sec_cnt  = sec_cnt_ff;
        nxt_tripped  = tripped_ff;
        if (tick && sec_cnt_ff != 12'hfff) begin
            nxt_sec_cnt = sec_cnt_ff + 12'h001;
        end
        if (refresh) begin
            nxt_tick_cnt = 32'h0000_0000;
            nxt_sec_cnt  = 12'h000;
            nxt_tripped  = 1'b0;
        end
        if (eff_timeout == 12'h000) begin
            nxt_tick_cnt = 32'h0000_0000;
            nxt_sec_cnt  = 12'h000;
            nxt_tripped  = 1'b0;
        // expiry sets, and wins over a same-cycle refresh.
        end else if (sec_cnt_ff >= eff_timeout && !tripped_ff) begin
            // Only the crossing sets the flag, so a refresh can clear a standing trip.
            nxt_tripped = 1'b1;
        end
        nxt_fail_active = nxt_tripped && (cfg_ff.loss_position != aab_pkg::LOSS_POS_LAST);
    end

    always_ff @(posedge i_core_clk or negedge i_resetn) begin
        if (!i_resetn) begin
            tick_cnt_ff    <= 32'h0000_0000;
            sec_cnt_ff     <= 12'h000;
            tripped_ff     <= 1'b0;
            fail_active_ff <= 1'b0;
        end else begin
            tick_cnt_ff    <= nxt_tick_cnt;
            sec_cnt_ff     <= nxt_sec_cnt;
            tripped_ff     <= nxt_tripped;
            fail_active_ff <= nxt_fail_active;
        end
    end

    always_comb begin
        malf_word = i_malfunction_bits;
        malf_word[aab_pkg::MALF_WATCHDOG_BIT] = tripped_ff;
    end

    // Reads answer one cycle later; unmapped addresses read as zero.
    always_comb begin
        nxt_rd_valid = i_rd.en;
        nxt_rd_data  = 16'h0000;
        if (i_rd.en) begin
            case (i_rd.addr)
                aab_pkg::ADDR_MALFUNCTION:     nxt_rd_data = malf_word;
                aab_pkg::ADDR_VMAX:            nxt_rd_data = cfg_ff.vmax;
                aab_pkg::ADDR_SENSOR_TYPE:     nxt_rd_data = {13'h0000, cfg_ff.sensor_type};
                aab_pkg::ADDR_LOSS_POSITION:   nxt_rd_data = {14'h0000, cfg_ff.loss_position};
                aab_pkg::ADDR_LOSS_TIMEOUT:    nxt_rd_data = {4'h0, eff_timeout};
                aab_pkg::ADDR_RATED_M3H:       nxt_rd_data = i_rated_flow_m3h;
                aab_pkg::ADDR_RATED_UNIT_LOW:  nxt_rd_data = i_rated_flow_unit[15:0];
                aab_pkg::ADDR_RATED_UNIT_HIGH: nxt_rd_data = i_rated_flow_unit[31:16];
                aab_pkg::ADDR_REGULATION_MODE: nxt_rd_data = {15'h0000, cfg_ff.regulation_mode};
                aab_pkg::ADDR_FLOW_UNIT:       nxt_rd_data = {13'h0000, cfg_ff.selected_flow_unit};
                aab_pkg::ADDR_SETPOINT_ORIGIN: nxt_rd_data = {15'h0000, cfg_ff.setpoint_origin};
                aab_pkg::ADDR_ANALOG_MV: begin
                    if (cfg_ff.setpoint_origin == aab_pkg::ORIGIN_ANALOG
                        && cfg_ff.sensor_type == aab_pkg::SENSOR_ACTIVE) begin
                        nxt_rd_data = i_analog_mv;
                    end
                end
                default:                       nxt_rd_data = 16'h0000;
            endcase
        end
    end

    always_ff @(posedge i_core_clk or negedge i_resetn) begin
        if (!i_resetn) begin
            rd_data_ff  <= 16'h0000;
            rd_valid_ff <= 1'b0;
        end else begin
            rd_data_ff  <= nxt_rd_data;
            rd_valid_ff <= nxt_rd_valid;
        end
    end

    assign o_rd_data          = rd_data_ff;
    assign o_rd_valid         = rd_valid_ff;
    assign o_cfg              = cfg_ff;
    assign o_watchdog_tripped = tripped_ff;
    assign o_fail_active      = fail_active_ff;

endmodule // aab_regs
`default_nettype wire

// *** aab_regs_assertions.sv ***
// Port assertions for the watchdog register bank.
`timescale 1ns/1ns
`default_nettype none
module aab_regs_assertions #(
    parameter int unsigned TICK_CYCLES = 4
) (
    input wire logic                 i_core_clk,
    input wire logic                 i_resetn,
    input wire aab_pkg::aab_wr_type  i_wr,
    input wire aab_pkg::aab_rd_type  i_rd,
    input wire logic [15:0]          i_malfunction_bits,
    input wire logic [15:0]          i_rated_flow_m3h,
    input wire logic [31:0]          i_rated_flow_unit,
    input wire logic [15:0]          i_analog_mv,
    input wire logic [15:0]          o_rd_data,
    input wire logic                 o_rd_valid,
    input wire aab_pkg::aab_cfg_type o_cfg,
    input wire logic                 o_watchdog_tripped,
    input wire logic                 o_fail_active
);
    logic [11:0] eff;
    logic [31:0] lim;
    logic [31:0] since_ff;
    logic [31:0] nxt_since;
    assign eff = o_cfg.timeout_set ? o_cfg.loss_timeout_s :
        (o_cfg.loss_position != 2'h0) ? aab_pkg::DFLT_ARMED_TIMEOUT : 12'h000;
    assign lim = 32'(eff) * TICK_CYCLES + 32'h1;
    // Cycles since the last refresh; held at zero while the watchdog is off.
    always_comb begin
        nxt_since = since_ff + 32'h1;
        if ((i_wr.en && i_wr.addr[15:1] == 15'h0) || eff == 12'h000) begin
            nxt_since = 32'h0;
        end
    end
    always_ff @(posedge i_core_clk or negedge i_resetn) begin
        if (!i_resetn) begin
            since_ff <= 32'h0;
        end else begin
            since_ff <= nxt_since;
        end
    end
    default clocking cb @(posedge i_core_clk); endclocking
    default disable iff (!i_resetn);
    property p_rd_valid; o_rd_valid == $past(i_rd.en); endproperty
    a_rd_valid: assert property (p_rd_valid) else $error("read valid wrong");
    property p_rated; i_rd.en && i_rd.addr[15:1] == 15'h0038 |=> o_rd_data ==
        ($past(i_rd.addr[0]) ? $past(i_rated_flow_unit[31:16]) : $past(i_rated_flow_unit[15:0]));
    endproperty
    a_rated: assert property (p_rated) else $error("rated flow word wrong");
    property p_analog; i_rd.en && i_rd.addr == aab_pkg::ADDR_ANALOG_MV |=> o_rd_data ==
        ((!$past(o_cfg.setpoint_origin) && $past(o_cfg.sensor_type) == 3'h1) ? $past(i_analog_mv) : 16'h0);
    endproperty
    a_analog: assert property (p_analog) else $error("analog readback wrong");
    property p_bit10; i_rd.en && i_rd.addr == aab_pkg::ADDR_MALFUNCTION |=> o_rd_data[10] ==
        $past(o_watchdog_tripped) && o_rd_data[9:8] == $past(i_malfunction_bits[9:8]);
    endproperty
    a_bit10: assert property (p_bit10) else $error("malfunction word wrong");
    property p_fail; o_fail_active |-> o_watchdog_tripped; endproperty
    a_fail: assert property (p_fail) else $error("fail drive without trip");
    property p_clear; $fell(o_watchdog_tripped) |->
        $past(i_wr.en) || $past(i_wr.en, 2) || $past(i_wr.en, 3);
    endproperty
    a_clear: assert property (p_clear) else $error("trip cleared without write");
    property p_zero; eff == 12'h000 [*2] |-> !o_watchdog_tripped; endproperty
    a_zero: assert property (p_zero) else $error("trip while disabled");
    property p_late; eff != 12'h000 && since_ff == lim |-> o_watchdog_tripped; endproperty
    a_late: assert property (p_late) else $error("trip late");
    property p_early; $rose(o_watchdog_tripped) |-> since_ff >= lim; endproperty
    a_early: assert property (p_early) else $error("trip early");
endmodule // aab_regs_assertions
bind aab_regs aab_regs_assertions #(.TICK_CYCLES(TICK_CYCLES)) chk_u (
    .i_core_clk(i_core_clk), .i_resetn(i_resetn), .i_wr(i_wr), .i_rd(i_rd),
    .i_malfunction_bits(i_malfunction_bits), .i_rated_flow_m3h(i_rated_flow_m3h),
    .i_rated_flow_unit(i_rated_flow_unit), .i_analog_mv(i_analog_mv), .o_rd_data(o_rd_data),
    .o_rd_valid(o_rd_valid), .o_cfg(o_cfg), .o_watchdog_tripped(o_watchdog_tripped),
    .o_fail_active(o_fail_active));
`default_nettype wire

// *** aab_master_model.sv ***
// Field bus master model issuing single register writes and reads.
`timescale 1ns/1ns
`default_nettype none
module aab_master_model (
    input  wire logic           i_core_clk,
    input  wire logic           i_rd_valid,
    input  wire logic [15:0]    i_rd_data,
    output aab_pkg::aab_wr_type o_wr,
    output aab_pkg::aab_rd_type o_rd
);
    initial begin
        o_wr = '0;
        o_rd = '0;
    end
    // Released fields show inverted values so nothing relies on stale ones.
    task automatic wr(input logic [15:0] a, input logic [15:0] d);
        @(negedge i_core_clk);
        o_wr = '{en: 1'b1, addr: a, data: d};
        @(negedge i_core_clk);
        o_wr = '{en: 1'b0, addr: ~a, data: ~d};
    endtask
    task automatic refresh(input logic [15:0] a);
        wr(a, 16'h0000);
    endtask
    task automatic rd(input logic [15:0] a, output logic [15:0] d, output logic v);
        @(negedge i_core_clk);
        o_rd = '{en: 1'b1, addr: a};
        @(negedge i_core_clk);
        o_rd = '{en: 1'b0, addr: ~a};
        d = i_rd_data;
        v = i_rd_valid;
    endtask
endmodule // aab_master_model
`default_nettype wire

// *** test_airflow_actuator_bus_watchdog_regs.sv ***
// Self-checking bench for the watchdog register bank.
`timescale 1ns/1ns
`default_nettype none
module test_airflow_actuator_bus_watchdog_regs;
    localparam logic [15:0] RA [11] = '{16'h6b, 16'h6c, 16'h6d, 16'h74, 16'h75, 16'h76,
        16'h6a, 16'h6e, 16'h70, 16'h71, 16'h6f};
    localparam logic [15:0] RV [11] = '{16'h0, 16'h0, 16'h0, 16'h0, 16'h1, 16'h1,
        16'h2710, 16'h0fa0, 16'h38d7, 16'h0013, 16'h0};
    logic                 i_core_clk;
    logic                 i_resetn;
    aab_pkg::aab_wr_type  wr;
    aab_pkg::aab_rd_type  rd;
    aab_pkg::aab_cfg_type cfg;
    logic [15:0]          malf;
    logic [15:0]          mv;
    logic [15:0]          rdat;
    logic [31:0]          uflow;
    logic                 rval;
    logic                 trip;
    logic                 fail;
    int                   n_mismatch;
    int                   n_checks;
    int                   k;
    aab_master_model mst (.i_core_clk(i_core_clk), .i_rd_valid(rval), .i_rd_data(rdat),
        .o_wr(wr), .o_rd(rd));
    aab_regs #(.TICK_CYCLES(4)) dut_u (.i_core_clk(i_core_clk), .i_resetn(i_resetn),
        .i_wr(wr), .i_rd(rd), .i_malfunction_bits(malf), .i_rated_flow_m3h(16'h0fa0),
        .i_rated_flow_unit(uflow), .i_analog_mv(mv), .o_rd_data(rdat), .o_rd_valid(rval),
        .o_cfg(cfg), .o_watchdog_tripped(trip), .o_fail_active(fail));
    task automatic chk(input string nm, input logic [15:0] seen, input logic [15:0] exp);
        n_checks++;
        if (seen !== exp) begin
            n_mismatch++;
            $display("ERROR %s expected %h seen %h", nm, exp, seen);
        end
    endtask
    task automatic rchk(input logic [15:0] a, input logic [15:0] exp);
        logic [15:0] d;
        logic        v;
        mst.rd(a, d, v);
        chk("rd_valid", {15'h0, v}, 16'h1);
        chk($sformatf("reg_%h", a), d, exp);
    endtask
    task automatic print_verdict();
        $display("checks %0d mismatches %0d", n_checks, n_mismatch);
        if (n_mismatch == 0 && n_checks > 0) $display("Regression OK");
        else $display("Regression broken");
        $finish;
    endtask
    // Timeout of 2 s at 4 cycles a second trips nine cycles after the refresh, seen as k of 10.
    task automatic wait_trip();
        k = 1;
        while (trip !== 1'b1 && k < 200) begin
            @(negedge i_core_clk);
            k++;
        end
        if (k >= 200) begin
            n_mismatch++;
            print_verdict();
        end
        chk("trip_cycles", 16'(k), 16'd10);
    endtask
    initial begin
        i_core_clk = 1'b0;
        forever #2 i_core_clk = ~i_core_clk;
    end
    initial begin
        i_resetn = 1'b0;
        malf = 16'h0306;
        mv = 16'h1d4c;
        uflow = 32'h0013_38d7;
        n_mismatch = 0;
        n_checks = 0;
        repeat (6) @(negedge i_core_clk);
        i_resetn = 1'b1;
        foreach (RA[i]) rchk(RA[i], RV[i]);
        mst.wr(16'h006a, 16'h1388);
        rchk(16'h006a, 16'h1388);
        chk("cfg_vmax", cfg.vmax, 16'h1388);
        mst.wr(16'h0074, 16'h1);
        rchk(16'h0074, 16'h1);
        mst.wr(16'h0074, 16'h2);
        rchk(16'h0074, 16'h1);
        chk("cfg_mode", {15'h0, cfg.regulation_mode}, 16'h1);
        mst.wr(16'h0070, 16'h1234);
        uflow = 32'hbeef_0042;
        rchk(16'h0070, 16'h0042);
        rchk(16'h0071, 16'hbeef);
        for (int u = 0; u < 8; u++) begin
            mst.wr(16'h0075, 16'(u));
            rchk(16'h0075, (u < 7) ? 16'(u) : 16'h6);
        end
        chk("cfg_unit", {13'h0, cfg.selected_flow_unit}, 16'h6);
        for (int s = 1; s < 5; s++) begin
            mst.wr(16'h006b, 16'(5 - s));
            rchk(16'h006b, (s == 4) ? 16'h1 : 16'h4);
        end
        mst.wr(16'h0076, 16'h0);
        rchk(16'h0077, 16'h1d4c);
        mst.wr(16'h0076, 16'h1);
        rchk(16'h0077, 16'h0);
        for (int p = 0; p < 5; p++) begin
            mst.wr(16'h006c, 16'(p));
            rchk(16'h006c, (p < 4) ? 16'(p) : 16'h3);
        end
        rchk(16'h006d, 16'd120);
        mst.wr(16'h006d, 16'd3600);
        mst.wr(16'h006d, 16'd3601);
        rchk(16'h006d, 16'd3600);
        chk("cfg_timeout", {4'h0, cfg.loss_timeout_s}, 16'd3600);
        chk("cfg_position", {14'h0, cfg.loss_position}, 16'h3);
        mst.wr(16'h006d, 16'd2);
        mst.refresh(16'h0000);
        wait_trip();
        chk("fail", {15'h0, fail}, 16'h1);
        rchk(16'h0068, 16'h0706);
        mst.wr(16'h006c, 16'h0);
        mst.refresh(16'h0001);
        chk("trip_clear", {15'h0, trip}, 16'h0);
        wait_trip();
        chk("fail_last", {15'h0, fail}, 16'h0);
        mst.wr(16'h006d, 16'h0);
        repeat (40) @(negedge i_core_clk);
        chk("trip_off", {15'h0, trip}, 16'h0);
        print_verdict();
    end
endmodule // test_airflow_actuator_bus_watchdog_regs
`default_nettype wire
